// ---- verilog/sep_pkg.sv ----
package sep_pkg;

  // core clock period
  localparam int CLK_PERIOD_NS = 4;
  // plain default for the self-timed write cycle
  localparam int WRITE_TIME_NS_DEF = 1000000;

  // instruction codes
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

  // status byte field positions
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BPL = 2;
  localparam int ST_BPH = 3;
  localparam int ST_SWD = 7;

  // frame geometry
  localparam int ADDR_W = 14;
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] CNT_MAX = 3'h7;
  localparam logic [2:0] CNT_OPCODE = 3'h0;
  localparam logic [2:0] CNT_ADDR_HI = 3'h1;
  localparam logic [2:0] CNT_ADDR_LO = 3'h2;
  localparam logic [2:0] LEN_LATCH = 3'h1;
  localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
  localparam logic [2:0] LEN_ARRAY_WRITE_MIN = 3'h4;

  // block protect encodings and bounds
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [ADDR_W-1:0] QUARTER_BASE = 14'h3000;
  localparam logic [ADDR_W-1:0] HALF_BASE = 14'h2000;

  // reset value of the non-volatile bits (delivery state)
  localparam logic NV_RESET = 1'b0;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_LATCH_SET = 3'h1,
    CMD_LATCH_CLEAR = 3'h2,
    CMD_STATUS_READ = 3'h3,
    CMD_STATUS_WRITE = 3'h4,
    CMD_ARRAY_READ = 3'h5,
    CMD_ARRAY_WRITE = 3'h6
  } sep_cmd_e;

  // opcode to command
  function automatic sep_cmd_e sep_decode(input logic [7:0] op);
    sep_cmd_e c;
    c = CMD_NONE;
    unique case (op)
      OP_LATCH_SET: c = CMD_LATCH_SET;
      OP_LATCH_CLEAR: c = CMD_LATCH_CLEAR;
      OP_STATUS_READ: c = CMD_STATUS_READ;
      OP_STATUS_WRITE: c = CMD_STATUS_WRITE;
      OP_ARRAY_READ: c = CMD_ARRAY_READ;
      OP_ARRAY_WRITE: c = CMD_ARRAY_WRITE;
      default: c = CMD_NONE;
    endcase
    return c;
  endfunction

  // protected area lookup
  function automatic logic sep_is_protected(input logic [1:0] bp,
                                            input logic [ADDR_W-1:0] addr);
    logic p;
    p = 1'b0;
    unique case (bp)
      BP_NONE: p = 1'b0;
      BP_QUARTER: p = (addr >= QUARTER_BASE);
      BP_HALF: p = (addr >= HALF_BASE);
      BP_ALL: p = 1'b1;
    endcase
    return p;
  endfunction

endpackage

// ---- verilog/sep_link_if.sv ----
`timescale 1ns/1ns
// what the serial receiver has gathered in the current or last frame
interface sep_link_if;
  import sep_pkg::*;
  logic frameLive;
  logic ignore;
  logic [7:0] opcode;
  logic [2:0] byteCnt;
  logic [2:0] bitIdx;
  logic [ADDR_W-1:0] addr;
  logic [BYTE_W-1:0] dataByte;

  modport rx
  (
    output frameLive,
    output ignore,
    output opcode,
    output byteCnt,
    output bitIdx,
    output addr,
    output dataByte
  );

  modport core
  (
    input frameLive,
    input ignore,
    input opcode,
    input byteCnt,
    input bitIdx,
    input addr,
    input dataByte
  );
endinterface

// ---- verilog/sep_link_rx.sv ----
`timescale 1ns/1ns
// serial receiver, runs on the link clock only
module sep_link_rx
  import sep_pkg::*;
(
  input wire logic sclk,
  input wire logic csN,
  input wire logic rst_b,
  input wire logic sdi,
  sep_link_if.rx link
);

  logic armed;
  logic ignore;
  logic [7:0] shifter;
  logic [7:0] opcode;
  logic [2:0] byteCnt;
  logic [2:0] bitIdx;
  logic [ADDR_W-1:0] addr;
  logic [BYTE_W-1:0] dataByte;
  logic [7:0] next_shifter;
  logic [7:0] next_opcode;
  logic [2:0] next_byteCnt;
  logic [2:0] next_bitIdx;
  logic [ADDR_W-1:0] next_addr;
  logic [BYTE_W-1:0] next_dataByte;
  logic next_ignore;

  // marks that the current frame has seen its first edge; deselect clears it
  always_ff @(posedge sclk or posedge csN)
  begin
    if (csN)
      armed <= 1'b0;
    else
      armed <= 1'b1;
  end

  // next frame state; a fresh frame starts from zero counts
  always_comb
  begin
    logic [2:0] idx;
    logic [2:0] cnt;
    logic [7:0] inByte;
    idx = armed ? bitIdx : BIT_FIRST;
    cnt = armed ? byteCnt : CNT_OPCODE;
    inByte = {(armed ? shifter[6:0] : 7'h00), sdi};
    next_shifter = inByte; // msb first
    next_bitIdx = idx + 3'h1;
    next_byteCnt = cnt;
    next_opcode = opcode;
    next_addr = addr;
    next_dataByte = dataByte;
    next_ignore = armed ? ignore : 1'b0;
    if (idx == BIT_LAST)
    begin
      if (cnt != CNT_MAX)
        next_byteCnt = cnt + 3'h1;
      if (cnt == CNT_OPCODE)
      begin
        next_opcode = inByte; // see [R05]
        next_ignore = (sep_decode(inByte) == CMD_NONE); // see [R07]
      end
      if (cnt == CNT_ADDR_HI)
      begin
        next_addr = {inByte[ADDR_W-9:0], addr[7:0]}; // see [R08]
        next_dataByte = inByte;
      end
      if (cnt == CNT_ADDR_LO)
        next_addr = {addr[ADDR_W-1:8], inByte};
    end
    if (armed && ignore)
    begin
      // deselected: hold everything until the next frame
      next_shifter = shifter;
      next_bitIdx = bitIdx;
      next_byteCnt = byteCnt;
      next_opcode = opcode;
      next_addr = addr;
      next_dataByte = dataByte;
      next_ignore = 1'b1;
    end
  end

  // frame registers hold their value after deselect for the core to read
  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shifter <= 8'h00;
      opcode <= 8'h00;
      byteCnt <= 3'h0;
      bitIdx <= 3'h0;
      addr <= 14'h0000;
      dataByte <= 8'h00;
      ignore <= 1'b0;
    end
    else
    begin
      shifter <= next_shifter;
      opcode <= next_opcode;
      byteCnt <= next_byteCnt;
      bitIdx <= next_bitIdx;
      addr <= next_addr;
      dataByte <= next_dataByte;
      ignore <= next_ignore;
    end
  end

  // results toward the core
  assign link.frameLive = armed;
  assign link.ignore = ignore;
  assign link.opcode = opcode;
  assign link.byteCnt = byteCnt;
  assign link.bitIdx = bitIdx;
  assign link.addr = addr;
  assign link.dataByte = dataByte;

endmodule // sep_link_rx

// ---- verilog/sep_eeprom_protect.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// [R01] write and status write run only if clock count is a multiple of eight
// [R02] deselect must follow the last latching edge before the next edge
// [R03] last bit is opcode or data byte end; no check for reads
// [R04] protect bits select none, upper quarter, upper half or whole array
// [R05] every frame starts with one opcode byte; set, clear latch, status read
// [R06] opcodes for status write, array read and array write
// [R07] unknown opcode deselects the device until the next frame
// [R08] only fourteen address bits are kept
// [R09] latch must be set by the set-latch command before each write
// [R10] set and clear latch complete only at deselect
// [R11] latch clears at reset, clear command and end of any write cycle
// [R12] status read allowed anytime and repeats while selected
// [R13] master should poll the busy flag during a write cycle
// [R14] busy flag is one during a write cycle, zero otherwise
// [R15] latch shows in status; writes refused while it is zero
// [R16] protect bits change only by status write outside hardware lock
// [R17] write-protect pin guards the protect bits
// [R18] hardware lock when write disable is one and protect pin low
// [R19] bits 6..4 read zero; status write leaves bits 6..4, 1, 0 alone
// [R20] status layout: busy 0, latch 1, protect 2 and 3, disable 7
// [R21] writes arriving during a write cycle are refused
module sep_eeprom_protect
  import sep_pkg::*;
#(
  parameter int WRITE_TIME_NS = WRITE_TIME_NS_DEF
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  input wire logic wpN,
  output logic sdo,
  output logic sdoOeN,
  output logic writeBusy,
  output logic hardwareLockMode,
  output logic arrayWriteGo,
  output logic [ADDR_W-1:0] arrayWriteAddr
);

  // write cycle length in core cycles, at least one
  localparam int WRITE_CYCLES_RAW = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int WRITE_CYCLES = (WRITE_CYCLES_RAW < 1) ? 1 : WRITE_CYCLES_RAW;
  localparam int TMR_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(WRITE_CYCLES - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO = '0;

  sep_link_if link ();

  // serial receiver on the link clock
  sep_link_rx u_rx
  (
    .sclk(sclk),
    .csN(csN),
    .rst_b(rst_b),
    .sdi(sdi),
    .link(link)
  );

  // ---- core domain ----
  logic csMeta;
  logic csSync;
  logic csSyncD;
  logic wpMeta;
  logic wpSync;
  logic write_enable_latch;
  logic write_busy_flag;
  logic bpLow;
  logic bpHigh;
  logic swd;
  logic pendBpLow;
  logic pendBpHigh;
  logic pendSwd;
  logic pendStatus;
  logic [TMR_W-1:0] tmr;
  logic deselect;
  logic hwLock;
  logic boundary;
  logic cycleDone;
  logic execSet;
  logic execClear;
  logic execStatusWrite;
  logic execArrayWrite;
  logic [7:0] statusByte;
  sep_cmd_e cmd;

  // two-flop synchronisers for chip select and the protect pin
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      csMeta <= 1'b1;
      csSync <= 1'b1;
      csSyncD <= 1'b1;
      wpMeta <= 1'b1;
      wpSync <= 1'b1;
    end
    else
    begin
      csMeta <= csN;
      csSync <= csMeta;
      csSyncD <= csSync;
      wpMeta <= wpN;
      wpSync <= wpMeta;
    end
  end

  // end of frame; the link clock is quiet so frame results are stable
  assign deselect = csSync & ~csSyncD;
  assign cmd = sep_decode(link.opcode);
  assign hwLock = swd & ~wpSync; // see [R18] [R17]
  assign boundary = (link.bitIdx == BIT_FIRST) && !link.ignore; // see [R01] [R02] [R07]
  assign cycleDone = write_busy_flag && (tmr == TMR_ZERO);

  // command execution, checked at deselect
  always_comb
  begin
    execSet = 1'b0;
    execClear = 1'b0;
    execStatusWrite = 1'b0;
    execArrayWrite = 1'b0;
    if (deselect && boundary)
    begin
      unique case (cmd)
        CMD_LATCH_SET:
          execSet = (link.byteCnt == LEN_LATCH); // see [R10] [R09] [R02]
        CMD_LATCH_CLEAR:
          execClear = (link.byteCnt == LEN_LATCH); // see [R10] [R02]
        CMD_STATUS_WRITE:
          execStatusWrite = (link.byteCnt == LEN_STATUS_WRITE) && write_enable_latch
                            && !write_busy_flag && !hwLock; // see [R15] [R21] [R16] [R03]
        CMD_ARRAY_WRITE:
          execArrayWrite = (link.byteCnt >= LEN_ARRAY_WRITE_MIN) && write_enable_latch && !write_busy_flag
                           && !sep_is_protected({bpHigh, bpLow}, link.addr); // see [R04] [R21]
        default:
        begin
          // reads and unknown codes need no execution; see [R03] [R06] [R12]
          execSet = 1'b0;
        end
      endcase
    end
  end

  // self-timed write cycle and busy flag
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      write_busy_flag <= 1'b0;
      tmr <= TMR_ZERO;
    end
    else if (execStatusWrite || execArrayWrite)
    begin
      write_busy_flag <= 1'b1; // see [R14]
      tmr <= TMR_LOAD;
    end
    else if (cycleDone)
      write_busy_flag <= 1'b0; // see [R14]
    else if (write_busy_flag)
      tmr <= tmr - 1'b1;
  end

  // write enable latch; a new set wins over the end-of-cycle clear
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      write_enable_latch <= 1'b0; // see [R11]
    else if (execSet)
      write_enable_latch <= 1'b1; // see [R09]
    else if (execClear || cycleDone)
      write_enable_latch <= 1'b0; // see [R11]
  end

  // status write values are held until the cycle completes
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pendBpLow <= NV_RESET;
      pendBpHigh <= NV_RESET;
      pendSwd <= NV_RESET;
      pendStatus <= 1'b0;
    end
    else if (execStatusWrite)
    begin
      pendBpLow <= link.dataByte[ST_BPL];
      pendBpHigh <= link.dataByte[ST_BPH];
      pendSwd <= link.dataByte[ST_SWD]; // bits 6..4, 1, 0 of the byte dropped, see [R19]
      pendStatus <= 1'b1;
    end
    else if (execArrayWrite)
      pendStatus <= 1'b0;
  end

  // non-volatile protect and disable bits
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bpLow <= NV_RESET;
      bpHigh <= NV_RESET;
      swd <= NV_RESET;
    end
    else if (cycleDone && pendStatus)
    begin
      bpLow <= pendBpLow; // see [R16]
      bpHigh <= pendBpHigh;
      swd <= pendSwd;
    end
  end

  // array write start toward the memory core
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      arrayWriteGo <= 1'b0;
      arrayWriteAddr <= 14'h0000;
    end
    else
    begin
      arrayWriteGo <= execArrayWrite;
      if (execArrayWrite)
        arrayWriteAddr <= link.addr; // see [R08]
    end
  end

  // registered status outputs
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      writeBusy <= 1'b0;
      hardwareLockMode <= 1'b0;
    end
    else
    begin
      writeBusy <= write_busy_flag;
      hardwareLockMode <= hwLock; // see [R18]
    end
  end

  // status byte image
  always_comb
  begin
    statusByte = 8'h00; // unused bits read zero, see [R19]
    statusByte[ST_BUSY] = write_busy_flag; // see [R20] [R14]
    statusByte[ST_WEL] = write_enable_latch; // see [R15]
    statusByte[ST_BPL] = bpLow;
    statusByte[ST_BPH] = bpHigh;
    statusByte[ST_SWD] = swd;
  end

  // ---- link domain: status shift-out ----
  logic [7:0] statMeta;
  logic [7:0] statSync;
  logic readMode;

  // each status bit is an independent level, so a per-bit two-flop crossing suffices
  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      statMeta <= 8'h00;
      statSync <= 8'h00;
    end
    else
    begin
      statMeta <= statusByte;
      statSync <= statMeta;
    end
  end

  // status read after the opcode byte, while the frame lasts
  assign readMode = link.frameLive && !link.ignore && (link.opcode == OP_STATUS_READ)
                    && (link.byteCnt != CNT_OPCODE);

  // output on falling edges, msb first, repeating the byte
  always_ff @(negedge sclk or posedge csN)
  begin
    if (csN)
    begin
      sdo <= 1'b0;
      sdoOeN <= 1'b1;
    end
    else if (readMode)
    begin
      sdo <= statSync[BIT_LAST - link.bitIdx]; // see [R12]
      sdoOeN <= 1'b0;
    end
    else
    begin
      sdo <= 1'b0;
      sdoOeN <= 1'b1;
    end
  end

endmodule // sep_eeprom_protect

// ---- testbench/sep_eeprom_protect_monitor.sv ----
`timescale 1ns/1ns
// port checks in the core clock domain
module sep_eeprom_protect_monitor
  import sep_pkg::*;
#(
  parameter int WRITE_TIME_NS = WRITE_TIME_NS_DEF
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  input wire logic wpN,
  input wire logic sdo,
  input wire logic sdoOeN,
  input wire logic writeBusy,
  input wire logic hardwareLockMode,
  input wire logic arrayWriteGo,
  input wire logic [ADDR_W-1:0] arrayWriteAddr
);
  localparam int WCYC = WRITE_TIME_NS / CLK_PERIOD_NS;
  int busyLen;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // length of the current busy run
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      busyLen <= 0;
    else if (writeBusy)
      busyLen <= busyLen + 1;
    else
      busyLen <= 0;
  end
  // busy follows an accepted write
  sequence busyStart;
    ##[0:2] writeBusy;
  endsequence
  oe_idle_a: assert property (csN |-> sdoOeN)
    else $error("output enabled while deselected");
  go_pulse_a: assert property (arrayWriteGo |=> !arrayWriteGo)
    else $error("write start longer than one cycle");
  go_busy_a: assert property (arrayWriteGo |-> busyStart)
    else $error("write start without busy");
  no_go_busy_a: assert property (arrayWriteGo |-> !$past(writeBusy))
    else $error("write accepted while busy");
  lock_wp_a: assert property ($past(wpN, 2) && $past(wpN, 3) && $past(wpN, 4)
    |-> !hardwareLockMode)
    else $error("lock with protect pin high");
  busy_len_a: assert property ($fell(writeBusy) |-> busyLen == WCYC)
    else $error("busy run length wrong");
  busy_cs_a: assert property ($rose(writeBusy) |-> $past(csN, 2))
    else $error("write cycle while selected");
  addr_go_a: assert property ($changed(arrayWriteAddr) |-> arrayWriteGo)
    else $error("address moved without start");
endmodule // sep_eeprom_protect_monitor

bind sep_eeprom_protect sep_eeprom_protect_monitor #(.WRITE_TIME_NS(WRITE_TIME_NS)) u_mon
(
  .core_clk(core_clk),
  .rst_b(rst_b),
  .sclk(sclk),
  .csN(csN),
  .sdi(sdi),
  .wpN(wpN),
  .sdo(sdo),
  .sdoOeN(sdoOeN),
  .writeBusy(writeBusy),
  .hardwareLockMode(hardwareLockMode),
  .arrayWriteGo(arrayWriteGo),
  .arrayWriteAddr(arrayWriteAddr)
);

// ---- testbench/sep_spi_master.sv ----
`timescale 1ns/1ns
// serial master at the far side, clock idles low
module sep_spi_master
(
  output logic sclk,
  output logic csN,
  output logic sdi,
  input wire logic sdo,
  output logic [7:0] rdByte,
  output logic rdTick
);
  // idle bus
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
    rdByte = 8'h00;
    rdTick = 1'b0;
  end
  // one frame of n bits msb first, then one status byte if rd
  task automatic xfer(input logic [31:0] v, input int n, input logic rd);
    int i;
    csN = 1'b0;
    for (i = 0; i < n + (rd ? 8 : 0); i++)
    begin
      sdi = (i < n) ? v[31 - i] : ~sdi; // data toggles once unused
      #15 sclk = 1'b1;
      if (i >= n)
        rdByte = {rdByte[6:0], sdo};
      #15 sclk = 1'b0;
    end
    csN = 1'b1;
    sdi = ~sdi;
    if (rd)
      rdTick = ~rdTick;
    #120;
  endtask
endmodule // sep_spi_master

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns
// self-checking bench for the command and protection block
module testbench;
  import sep_pkg::*;
  logic core_clk, rst_b, wpN, sclk, csN, sdi, sdo, sdoOeN;
  logic writeBusy, hwLock, go, rdTick;
  logic [ADDR_W-1:0] goAddr;
  logic [7:0] rdByte;
  logic [7:0] stQ[$];
  logic [ADDR_W-1:0] adQ[$];
  logic [31:0] lfsr = 32'ha555;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  sep_eeprom_protect #(.WRITE_TIME_NS(2000)) u_dut
  (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sclk(sclk),
    .csN(csN),
    .sdi(sdi),
    .wpN(wpN),
    .sdo(sdo),
    .sdoOeN(sdoOeN),
    .writeBusy(writeBusy),
    .hardwareLockMode(hwLock),
    .arrayWriteGo(go),
    .arrayWriteAddr(goAddr)
  );
  sep_spi_master u_mst
  (
    .sclk(sclk),
    .csN(csN),
    .sdi(sdi),
    .sdo(sdo),
    .rdByte(rdByte),
    .rdTick(rdTick)
  );
  // core clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic st(input logic [7:0] e);
    stQ.push_back(e);
    u_mst.xfer({OP_STATUS_READ, 24'h0}, 8, 1'b1);
  endtask
  task automatic sw(input logic [7:0] d, input int n);
    u_mst.xfer({OP_STATUS_WRITE, d, 16'h0}, n, 1'b0);
  endtask
  task automatic write_enable_latch();
    u_mst.xfer({OP_LATCH_SET, 24'h0}, 8, 1'b0);
  endtask
  task automatic aw(input logic [15:0] a, input logic ok);
    lfsr = nxt(lfsr);
    if (ok)
      adQ.push_back(a[ADDR_W-1:0]);
    u_mst.xfer({OP_ARRAY_WRITE, a, lfsr[7:0]}, 32, 1'b0);
  endtask
  // status bytes as the master collects them
  always @(rdTick)
    if ($time > 0)
    begin
      if (stQ.size() == 0)
        chk("status extra", 16'h0001, 16'h0000);
      else
        chk("status", {8'h00, rdByte}, {8'h00, stQ.pop_front()});
    end
  // accepted array writes; a start with no note is a refused write that went through
  always @(negedge core_clk)
    if (go === 1'b1)
    begin
      if (adQ.size() == 0)
        chk("write extra", 16'h0001, 16'h0000);
      else
        chk("write addr", {2'h0, goAddr}, {2'h0, adQ.pop_front()});
    end
  // hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      wrap_up();
    end
  end
  // main sequence
  initial
  begin
    rst_b = 1'b0;
    wpN = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge core_clk);
    #7;
    st(8'h00);
    write_enable_latch();
    st(8'h02);
    u_mst.xfer({OP_LATCH_CLEAR, 24'h0}, 8, 1'b0);
    st(8'h00);
    sw(8'h8c, 16);
    st(8'h00);
    u_mst.xfer({8'h07, OP_LATCH_SET, 16'h0}, 16, 1'b0);
    st(8'h00);
    u_mst.xfer({OP_LATCH_SET, 24'h0}, 9, 1'b0);
    st(8'h00);
    write_enable_latch();
    sw(8'h8c, 15);
    st(8'h02);
    $display("test decode done");
    lfsr = nxt(lfsr);
    aw(lfsr[15:0], 1'b1);
    sw(8'h8c, 16);
    st(8'h03);
    #2200;
    st(8'h00);
    $display("test busy done");
    write_enable_latch();
    sw(8'hff, 16);
    #2200;
    st(8'h8c);
    write_enable_latch();
    aw(16'h0000, 1'b0);
    st(8'h8e);
    sw(8'h04, 16);
    #2200;
    write_enable_latch();
    aw(16'h3000, 1'b0);
    aw(16'h2fff, 1'b1);
    #2200;
    st(8'h04);
    $display("test protect done");
    write_enable_latch();
    sw(8'h80, 16);
    #2200;
    @(posedge core_clk);
    #1 wpN = 1'b0;
    repeat (6) @(posedge core_clk);
    chk("lock", {15'h0, hwLock}, 16'h0001);
    write_enable_latch();
    sw(8'h00, 16);
    st(8'h82);
    @(posedge core_clk);
    #1 wpN = 1'b1;
    repeat (6) @(posedge core_clk);
    chk("lock", {15'h0, hwLock}, 16'h0000);
    sw(8'h00, 16);
    #2200;
    st(8'h00);
    $display("test lock done");
    chk("writes left", 16'(adQ.size()), 16'h0000);
    chk("reads left", 16'(stQ.size()), 16'h0000);
    wrap_up();
  end
endmodule // testbench
